// File: src/serial_rx_status.v
// receive control and status for the serial unit: receiver, rx fifo,
// sticky flags and interrupt requests
// assumes a single-cycle register port on REF_CLK and pins from outside
`timescale 1ns/1ns
`include "serial_rx_regs.vh"

module serial_rx_status #(
  parameter BAUD_DIV = 68,
  parameter DEPTH_LOG = 4
) (
  input wire REF_CLK,
  input wire RESETN,
  input wire [7:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire RXD,
  input wire SERIAL_CLK_PIN,
  input wire TX_DONE_SET,
  input wire TX_LOW_SET,
  output reg RX_DATA_IRQ,
  output reg RX_FAULT_IRQ,
  output reg BREAK_IRQ
);

  localparam DEPTH = 1 << DEPTH_LOG;
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_BITS = 3'd2;
  localparam S_STOP = 3'd3;
  localparam S_BRK = 3'd4;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] rxd_sync_q;
  reg [1:0] sck_sync_q;
  reg sck_prev_q;
  wire rxd_s = rxd_sync_q[1];

  // two flops per pin; only the second stage is looked at
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      rxd_sync_q <= 2'b11;
      sck_sync_q <= 2'b00;
      sck_prev_q <= 1'b0;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], RXD};
      sck_sync_q <= {sck_sync_q[0], SERIAL_CLK_PIN};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] control_reg_q;
  reg [15:0] mode_reg_q;
  reg [15:0] fifo_ctrl_reg_q;
  reg [7:0] flags_q;
  reg [7:0] armed_q;
  reg overrun_flag_q;
  reg overrun_armed_q;

  wire rx_on = control_reg_q[`RX_ON_BIT];
  wire rx_irq_on = control_reg_q[`RX_IRQ_ON_BIT];
  wire rx_fault_irq_on = control_reg_q[`RX_FAULT_IRQ_ON_BIT];
  wire ext_clk_select = control_reg_q[`EXT_CLK_SELECT_BIT];
  wire char7 = mode_reg_q[`CHAR7_BIT];
  wire parity_on = mode_reg_q[`PARITY_ON_BIT];
  wire parity_odd = mode_reg_q[`PARITY_ODD_BIT];
  wire fifo_rst = fifo_ctrl_reg_q[`RX_FIFO_RESET_BIT];

  wire wr_ctl = WR && (ADDR == `CONTROL_REG_OFS);
  wire wr_st = WR && (ADDR == `STATUS_REG_OFS);
  wire wr_mode = WR && (ADDR == `MODE_REG_OFS);
  wire wr_fctl = WR && (ADDR == `FIFO_CTRL_REG_OFS);
  wire wr_line = WR && (ADDR == `LINE_STAT_REG_OFS);
  wire rd_st = RD && (ADDR == `STATUS_REG_OFS);
  wire rd_fifo = RD && (ADDR == `RX_FIFO_OFS);
  wire rd_line = RD && (ADDR == `LINE_STAT_REG_OFS);

  // ----------------------------------------------------------------
  // 16x tick source
  // ----------------------------------------------------------------
  reg [15:0] div_q;
  wire int_tick = (div_q == BAUD_DIV[15:0] - 16'd1);
  wire ext_tick = sck_sync_q[1] & ~sck_prev_q;
  // internal divider or rising edge of the 16x pin clock
  wire tick = ext_clk_select ? ext_tick : int_tick; // RULE_07

  always @(posedge REF_CLK) begin
    if (!RESETN || int_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [3:0] tck_q;
  reg [3:0] idx_q;
  reg [8:0] sh_q;
  reg push;
  reg push_fer;
  reg push_per;
  reg brk_set;
  reg [7:0] push_data;
  wire [3:0] ndata = char7 ? 4'd7 : 4'd8;
  wire [3:0] nbits = parity_on ? ndata + 4'd1 : ndata;
  wire [7:0] dmask = char7 ? 8'h7F : 8'hFF;
  wire [7:0] rdata8 = sh_q[7:0] & dmask;
  wire par_bit = char7 ? sh_q[7] : sh_q[8];
  // ones in data plus parity must match even or odd choice
  wire par_bad = parity_on & ((^rdata8 ^ par_bit) != parity_odd); // RULE_17

  // stop-bit and parity verdicts at the first stop sample
  always @* begin
    push = 1'b0;
    push_fer = 1'b0;
    push_per = 1'b0;
    brk_set = 1'b0;
    push_data = rdata8;
    if (state_q == S_STOP && tick && tck_q == 4'd15) begin
      push_fer = ~rxd_s; // RULE_16
      push_per = par_bad;
      // a framed all-zero character on a low line is a break, not data
      if (push_fer && rdata8 == 8'h00 && !rxd_s) begin
        brk_set = 1'b1;
      end else begin
        push = 1'b1; // RULE_18
      end
    end
  end

  // dropping rx_on only parks the receiver; flags are left alone
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      state_q <= S_IDLE;
      tck_q <= 4'h0;
      idx_q <= 4'h0;
      sh_q <= 9'h000;
    end else if (!rx_on) begin
      state_q <= S_IDLE; // RULE_01
    end else if (tick) begin
      tck_q <= tck_q + 4'h1;
      case (state_q)
        S_IDLE: begin
          tck_q <= 4'h0;
          if (!rxd_s) begin
            state_q <= S_START; // RULE_02
          end
        end
        S_START: begin
          // mid start bit: a high line means a glitch
          if (tck_q == 4'd7) begin
            tck_q <= 4'h0;
            idx_q <= 4'h0;
            sh_q <= 9'h000;
            state_q <= rxd_s ? S_IDLE : S_BITS;
          end
        end
        S_BITS: begin
          if (tck_q == 4'd15) begin
            sh_q[idx_q] <= rxd_s;
            idx_q <= idx_q + 4'h1;
            if (idx_q == nbits - 4'd1) begin
              state_q <= S_STOP;
            end
          end
        end
        S_STOP: begin
          // only the first stop bit is checked
          if (tck_q == 4'd15) begin
            state_q <= brk_set ? S_BRK : S_IDLE; // RULE_16
          end
        end
        S_BRK: begin
          if (rxd_s) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rx fifo with per-byte fault bits
  // ----------------------------------------------------------------
  reg [9:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG-1:0] wp_q;
  reg [DEPTH_LOG-1:0] rp_q;
  reg [DEPTH_LOG:0] cnt_q;
  reg [3:0] per_cnt_q;
  reg [3:0] fer_cnt_q;
  wire empty = (cnt_q == 0);
  wire full = (cnt_q == DEPTH);
  wire do_push = push && !full && !fifo_rst;
  wire do_pop = rd_fifo && !empty && !fifo_rst;
  wire [9:0] head = mem[rp_q];
  wire head_fer = ~empty & head[8]; // RULE_19
  wire head_per = ~empty & head[9]; // RULE_19
  wire pop_fer = do_pop & head[8];
  wire pop_per = do_pop & head[9];

  always @(posedge REF_CLK) begin
    if (do_push) begin
      mem[wp_q] <= {push_per, push_fer, push_data};
    end
  end

  // counts wrap at sixteen, so a full fifo of faults reads zero
  always @(posedge REF_CLK) begin
    if (!RESETN || fifo_rst) begin
      wp_q <= {DEPTH_LOG{1'b0}};
      rp_q <= {DEPTH_LOG{1'b0}};
      cnt_q <= {(DEPTH_LOG+1){1'b0}};
      per_cnt_q <= 4'h0; // RULE_22
      fer_cnt_q <= 4'h0; // RULE_22
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{DEPTH_LOG{1'b0}}, do_push} - {{DEPTH_LOG{1'b0}}, do_pop};
      per_cnt_q <= per_cnt_q + {3'b000, do_push & push_per} - {3'b000, pop_per}; // RULE_13
      fer_cnt_q <= fer_cnt_q + {3'b000, do_push & push_fer} - {3'b000, pop_fer}; // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // idle-data timer and trigger level
  // ----------------------------------------------------------------
  reg [7:0] idle_q;
  reg [4:0] trig;
  wire idle_hit = (idle_q == `IDLE_TICKS - 8'd1) && tick;

  always @* begin
    case (fifo_ctrl_reg_q[7:6])
      2'b00: trig = 5'd1;
      2'b01: trig = 5'd4;
      2'b10: trig = 5'd8;
      default: trig = 5'd14;
    endcase
  end

  // counts quiet line time while any byte waits in the fifo, whatever the trigger
  always @(posedge REF_CLK) begin
    if (!RESETN || state_q != S_IDLE || empty || idle_hit) begin
      idle_q <= 8'h00;
    end else if (tick) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // status flags: set wins over clear
  // ----------------------------------------------------------------
  reg [7:0] set_v;
  reg [7:0] clr_v;
  wire [7:0] status_lo = {flags_q[7:4], head_fer, head_per, flags_q[1:0]};
  wire [15:0] status_init = `STATUS_RESET;

  always @* begin
    set_v = 8'h00;
    set_v[`FAULT_POS] = push & (push_fer | push_per);
    set_v[`TX_DONE_POS] = TX_DONE_SET | ~control_reg_q[`TX_ON_BIT]; // RULE_20
    set_v[`TX_LOW_POS] = TX_LOW_SET;
    set_v[`BREAK_POS] = brk_set;
    set_v[`RX_FULL_POS] = (cnt_q >= trig);
    set_v[`IDLE_DATA_POS] = idle_hit;
    // a zero clears only a flag armed by an earlier read of one
    clr_v = wr_st ? (~WDATA[7:0] & armed_q & `CLEARABLE_MASK) : 8'h00; // RULE_10
  end

  // frame and parity bits are never stored, so writes cannot touch them
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      flags_q <= status_init[7:0]; // RULE_12
      armed_q <= 8'h00;
      overrun_flag_q <= 1'b0;
      overrun_armed_q <= 1'b0;
    end else begin
      flags_q <= ((flags_q & ~clr_v) | set_v) & `CLEARABLE_MASK; // RULE_11
      if (rd_st) begin
        armed_q <= status_lo & `CLEARABLE_MASK;
      end else if (wr_st) begin
        armed_q <= 8'h00;
      end
      if (push && full) begin
        overrun_flag_q <= 1'b1;
      end else if (wr_line && !WDATA[0] && overrun_armed_q) begin
        overrun_flag_q <= 1'b0; // RULE_06
      end
      if (rd_line) begin
        overrun_armed_q <= overrun_flag_q;
      end else if (wr_line) begin
        overrun_armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control, mode and fifo control writes
  // ----------------------------------------------------------------
  // software is expected to fix mode and reset the fifo before rx_on
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      control_reg_q <= 16'h0000;
      mode_reg_q <= 16'h0000;
      fifo_ctrl_reg_q <= 16'h0000;
    end else begin
      if (wr_ctl) begin
        control_reg_q <= WDATA & `CONTROL_MASK;
      end
      if (wr_mode) begin
        mode_reg_q <= WDATA & `MODE_MASK;
      end
      if (wr_fctl) begin
        fifo_ctrl_reg_q <= WDATA & `FIFO_CTRL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  // either enable passes fault and break, so they survive rx_irq_on low
  wire fault_gate = rx_irq_on | rx_fault_irq_on; // RULE_04 RULE_05

  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      RX_DATA_IRQ <= 1'b0;
      RX_FAULT_IRQ <= 1'b0;
      BREAK_IRQ <= 1'b0;
    end else begin
      RX_DATA_IRQ <= rx_irq_on & (flags_q[`RX_FULL_POS] | flags_q[`IDLE_DATA_POS]); // RULE_21
      RX_FAULT_IRQ <= fault_gate & flags_q[`FAULT_POS]; // RULE_06
      BREAK_IRQ <= fault_gate & (flags_q[`BREAK_POS] | overrun_flag_q); // RULE_21
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (!RESETN || !RD) begin
      RDATA <= 16'h0000;
    end else begin
      case (ADDR)
        `CONTROL_REG_OFS: RDATA <= control_reg_q;
        `STATUS_REG_OFS: RDATA <= {per_cnt_q, fer_cnt_q, status_lo}; // RULE_09 RULE_15
        `MODE_REG_OFS: RDATA <= mode_reg_q;
        `FIFO_CTRL_REG_OFS: RDATA <= fifo_ctrl_reg_q;
        `RX_FIFO_OFS: RDATA <= {8'h00, head[7:0] & {8{~empty}}};
        `LINE_STAT_REG_OFS: RDATA <= {15'h0000, overrun_flag_q};
        default: RDATA <= 16'h0000;
      endcase
    end
  end

endmodule // serial_rx_status

// File: src/serial_rx_regs.vh
// constants for the receive control and status block of the serial unit
// assumes a 16-bit register port; offsets are byte addresses on that port
//
// Contract
// RULE_01 - clearing rx_on leaves all receive status flags as they are
// RULE_02 - with rx_on set, a start bit on the line begins a character
// RULE_03 - software sets mode, fifo control and resets rx fifo before rx_on
// RULE_04 - rx_fault_irq_on gates fault and break requests, valid while rx_irq_on low
// RULE_05 - rx_fault_irq_on high raises fault and break requests with rx_irq_on low
// RULE_06 - fault/break request drops on read-1 then clear, or both enables low
// RULE_07 - ext_clk_select low: internal clock; high: pin is 16x bit-rate clock
// RULE_08 - software sets ext_clk_select before programming the mode register
// RULE_09 - status is 16 bits: counts above, eight flags below in fixed order
// RULE_10 - sticky flags take only 0, and only after being read as 1
// RULE_11 - frame and parity flags are read-only
// RULE_12 - reset loads status with 0x0060
// RULE_13 - bits 15..12 count parity-faulty bytes in the rx fifo
// RULE_14 - bits 11..8 count frame-faulty bytes in the rx fifo
// RULE_15 - counts wrap: sixteen faulty bytes read as zero
// RULE_16 - a zero first stop bit sets rx_fault_sticky; the code does not set it when an all-zero character is taken as a break
// RULE_17 - parity mismatch against even/odd setting sets rx_fault_sticky
// RULE_18 - faulty characters still enter the fifo, reception continues
// RULE_19 - frame and parity flags describe the byte at the fifo head
// RULE_20 - tx_done_flag shows the transmitter ran dry after a character
// RULE_21 - rx_irq_on gates data, fault and break/overrun requests
// RULE_22 - error counts follow fifo contents and clear on fifo reset
`ifndef SERIAL_RX_REGS_VH
`define SERIAL_RX_REGS_VH
// register offsets
`define CONTROL_REG_OFS 8'h00
`define STATUS_REG_OFS 8'h04
`define MODE_REG_OFS 8'h08
`define FIFO_CTRL_REG_OFS 8'h0C
`define RX_FIFO_OFS 8'h10
`define LINE_STAT_REG_OFS 8'h14
// writable masks and reset values
`define CONTROL_MASK 16'h00FA
`define MODE_MASK 16'h0078
`define FIFO_CTRL_MASK 16'h00C2
`define STATUS_RESET 16'h0060
// control bits
`define TX_ON_BIT 5
`define RX_IRQ_ON_BIT 6
`define RX_ON_BIT 4
`define RX_FAULT_IRQ_ON_BIT 3
`define EXT_CLK_SELECT_BIT 1
// mode bits
`define CHAR7_BIT 6
`define PARITY_ON_BIT 5
`define PARITY_ODD_BIT 4
// fifo control bits
`define RX_FIFO_RESET_BIT 1
// status flag positions
`define FAULT_POS 7
`define TX_DONE_POS 6
`define TX_LOW_POS 5
`define BREAK_POS 4
`define FRAME_POS 3
`define PARITY_POS 2
`define RX_FULL_POS 1
`define IDLE_DATA_POS 0
// flags that software may clear
`define CLEARABLE_MASK 8'hF3
// idle time before the idle-data flag, in 16x ticks
`define IDLE_TICKS 8'd160
`endif

// File: tb/serial_rx_status_sva.sv
// checker for the serial receive status block, bound to its top ports
// assumes the register map of serial_rx_regs.vh and a single clock domain
`timescale 1ns/1ns
`include "serial_rx_regs.vh"
module serial_rx_status_sva (
  input wire REF_CLK,
  input wire RESETN,
  input wire [7:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire RX_DATA_IRQ,
  input wire RX_FAULT_IRQ,
  input wire BREAK_IRQ
);
  reg [15:0] ctl_q;
  wire data_on = ctl_q[`RX_IRQ_ON_BIT];
  wire err_on = data_on | ctl_q[`RX_FAULT_IRQ_ON_BIT];
  wire mapped = (ADDR < 8'h18) && (ADDR[1:0] == 2'b00);
  wire st_wr = WR && (ADDR == `STATUS_REG_OFS);
  wire st_rd = RD && (ADDR == `STATUS_REG_OFS);
  // control shadow, since the interrupt gates are not visible at the ports
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      ctl_q <= 16'h0000;
    end else if (WR && ADDR == `CONTROL_REG_OFS) begin
      ctl_q <= WDATA & `CONTROL_MASK;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  a_read_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property ($past(RD) && !$past(mapped) |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(RESETN) |-> RDATA == 16'h0000 && !BREAK_IRQ)
    else $error("outputs not quiet after reset");
  a_data_gate: assert property (!data_on && !$past(data_on) |-> !RX_DATA_IRQ)
    else $error("data request without its enable");
  a_fault_gate: assert property (!err_on && !$past(err_on) |-> !RX_FAULT_IRQ && !BREAK_IRQ)
    else $error("fault or break request with both enables low");
  a_fault_raise: assert property ($past(st_rd) && RDATA[`FAULT_POS] && $past(err_on) |-> RX_FAULT_IRQ)
    else $error("fault flag set but no fault request");
  a_data_raise: assert property ($past(st_rd) && RDATA[`RX_FULL_POS] && $past(data_on) |-> RX_DATA_IRQ)
    else $error("full flag set but no data request");
  a_fault_sticky: assert property ($past(RX_FAULT_IRQ) && !$past(st_wr, 2) && $past(err_on) |-> RX_FAULT_IRQ)
    else $error("fault request dropped without a status write");
endmodule // serial_rx_status_sva

bind serial_rx_status serial_rx_status_sva i_serial_rx_status_sva (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RX_DATA_IRQ(RX_DATA_IRQ), .RX_FAULT_IRQ(RX_FAULT_IRQ), .BREAK_IRQ(BREAK_IRQ));

// File: tb/serial_line_driver.sv
// remote serial transmitter model driving the receive line
// assumes the bench clock; bit length is given in clocks per call
`timescale 1ns/1ns
module serial_line_driver (
  input wire clk,
  output reg rxd
);
  integer i;
  // line idles high, as with its pull-up
  initial rxd = 1'b1;
  // start low, then n bits lsb first, then back to idle for one bit time
  task send(input [10:0] bits, input integer n, input integer len);
    begin
      @(posedge clk) rxd <= 1'b0;
      repeat (len) @(posedge clk);
      for (i = 0; i < n; i = i + 1) begin
        rxd <= bits[i];
        repeat (len) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (len) @(posedge clk);
    end
  endtask
endmodule // serial_line_driver

// File: tb/testbench.sv
// self-checking bench for the serial receive status block
// assumes the line driver model on the receive pin and the bound checker
`timescale 1ns/1ns
`include "serial_rx_regs.vh"
module testbench;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg pin = 1'b0;
  reg ext_run = 1'b0;
  reg low_set = 1'b0;
  reg done_set = 1'b0;
  wire [15:0] rdata;
  wire rxd;
  wire irq_d;
  wire irq_f;
  wire irq_b;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer k;
  reg [15:0] s;

  // short baud divider keeps each bit at 32 clocks
  serial_rx_status #(.BAUD_DIV(2), .DEPTH_LOG(4)) i_serial_rx_status (
    .REF_CLK(ref_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_en),
    .RD(rd_en), .RDATA(rdata), .RXD(rxd), .SERIAL_CLK_PIN(pin), .TX_DONE_SET(done_set),
    .TX_LOW_SET(low_set), .RX_DATA_IRQ(irq_d), .RX_FAULT_IRQ(irq_f), .BREAK_IRQ(irq_b));
  serial_line_driver i_serial_line_driver (.clk(ref_clk), .rxd(rxd));

  always #4 ref_clk = ~ref_clk;
  // cycle count for the hang limit; external 16x clock of period 4 clocks
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (ext_run && cyc[0]) pin <= ~pin;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end

  // ----------------------------------------
  // register port and compare tasks
  // ----------------------------------------
  task wr_reg(input [7:0] a, input [15:0] d);
    begin
      @(posedge ref_clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
      @(posedge ref_clk) wr_en <= 1'b0;
    end
  endtask
  // data stand only in the cycle after the strobe
  task rd_reg(input [7:0] a, output [15:0] d);
    begin
      @(posedge ref_clk) begin addr <= a; rd_en <= 1'b1; end
      @(posedge ref_clk) rd_en <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task chk(input [8*10:1] nm, input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task frame(input [7:0] d, input stp);
    i_serial_line_driver.send({2'b11, stp, d}, 9, 32);
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_reg(`STATUS_REG_OFS, s); chk("status", s, `STATUS_RESET);
    rd_reg(`CONTROL_REG_OFS, s); chk("control", s, 16'h0000);
    rd_reg(8'h20, s); chk("unmapped", s, 16'h0000);
    wr_reg(`STATUS_REG_OFS, 16'hFFFF);
    rd_reg(`STATUS_REG_OFS, s); chk("status", s, 16'h0060);
    wr_reg(`STATUS_REG_OFS, 16'hFFDF);
    rd_reg(`STATUS_REG_OFS, s); chk("tx low clr", s, 16'h0040);
    @(posedge ref_clk) low_set <= 1'b1;
    @(posedge ref_clk) low_set <= 1'b0;
    rd_reg(`STATUS_REG_OFS, s); chk("tx low set", s, 16'h0060);
    // fifo reset and format before the receiver is switched on
    wr_reg(`FIFO_CTRL_REG_OFS, 16'h0002);
    wr_reg(`FIFO_CTRL_REG_OFS, 16'h0000);
    wr_reg(`MODE_REG_OFS, 16'h0000);
    wr_reg(`CONTROL_REG_OFS, 16'h0050);
    frame(8'hA5, 1'b1);
    chk("data irq", {15'h0000, irq_d}, 16'h0001);
    rd_reg(`RX_FIFO_OFS, s); chk("rx byte", s, 16'h00A5);
    frame(8'h3C, 1'b0);
    rd_reg(`STATUS_REG_OFS, s); chk("frame err", s, 16'h01EA);
    // even parity, parity bit wrong for one set data bit
    wr_reg(`MODE_REG_OFS, 16'h0020);
    i_serial_line_driver.send({1'b1, 1'b0, 8'h01}, 10, 32);
    rd_reg(`STATUS_REG_OFS, s); chk("parity err", s, 16'h11EA);
    rd_reg(`RX_FIFO_OFS, s); chk("rx byte", s, 16'h003C);
    rd_reg(`STATUS_REG_OFS, s); chk("head", s, 16'h10E6);
    rd_reg(`RX_FIFO_OFS, s); chk("rx byte", s, 16'h0001);
    // receiver off, fault request alone; a clear without a prior read is ignored
    wr_reg(`CONTROL_REG_OFS, 16'h0008);
    wr_reg(`STATUS_REG_OFS, 16'hFFFF);
    wr_reg(`STATUS_REG_OFS, 16'hFF7F);
    chk("fault irq", {15'h0000, irq_f}, 16'h0001);
    rd_reg(`STATUS_REG_OFS, s); chk("rx off", s, 16'h00E2);
    wr_reg(`STATUS_REG_OFS, 16'hFF7F);
    rd_reg(`STATUS_REG_OFS, s); chk("fault clr", s, 16'h0062);
    chk("fault irq", {15'h0000, irq_f}, 16'h0000);
    // clock select first, then the format, then the receiver
    wr_reg(`CONTROL_REG_OFS, 16'h0002);
    wr_reg(`MODE_REG_OFS, 16'h0000);
    wr_reg(`CONTROL_REG_OFS, 16'h0012);
    ext_run = 1'b1;
    i_serial_line_driver.send({2'b11, 1'b1, 8'h5A}, 9, 64);
    ext_run = 1'b0;
    rd_reg(`RX_FIFO_OFS, s); chk("ext byte", s, 16'h005A);
    wr_reg(`CONTROL_REG_OFS, 16'h0010);
    // sixteen faulty bytes fill the fifo and wrap the count
    for (k = 0; k < 16; k = k + 1) frame(8'h80 + k[7:0], 1'b0);
    rd_reg(`STATUS_REG_OFS, s); chk("wrap", s, 16'h00EA);
    // all-zero framed character on a full fifo: break, not stored
    wr_reg(`CONTROL_REG_OFS, 16'h0018);
    frame(8'h00, 1'b0);
    chk("break irq", {15'h0000, irq_b}, 16'h0001);
    rd_reg(`STATUS_REG_OFS, s); chk("break", s, 16'h00FA);
    // one more byte on the full fifo is lost to overrun
    frame(8'h11, 1'b1);
    rd_reg(`LINE_STAT_REG_OFS, s); chk("overrun", s, 16'h0001);
    wr_reg(`LINE_STAT_REG_OFS, 16'h0000);
    rd_reg(`LINE_STAT_REG_OFS, s); chk("ovr clr", s, 16'h0000);
    chk("break irq", {15'h0000, irq_b}, 16'h0001);
    wr_reg(`CONTROL_REG_OFS, 16'h0010);
    repeat (2) @(posedge ref_clk);
    chk("break irq", {15'h0000, irq_b}, 16'h0000);
    // fifo reset, trigger of four, odd parity on 7-bit characters
    wr_reg(`FIFO_CTRL_REG_OFS, 16'h0042);
    wr_reg(`FIFO_CTRL_REG_OFS, 16'h0040);
    wr_reg(`MODE_REG_OFS, 16'h0070);
    rd_reg(`STATUS_REG_OFS, s);
    wr_reg(`STATUS_REG_OFS, 16'hFFFD);
    i_serial_line_driver.send({2'b11, 1'b1, 1'b1, 7'h55}, 9, 32);
    rd_reg(`STATUS_REG_OFS, s); chk("odd 7bit", s & 16'hF00E, 16'h0000);
    // a byte left waiting on a quiet line raises the idle-data flag
    repeat (400) @(posedge ref_clk);
    rd_reg(`STATUS_REG_OFS, s); chk("idle data", s & 16'h0001, 16'h0001);
    rd_reg(`RX_FIFO_OFS, s); chk("rx 7bit", s, 16'h0055);
    // transmitter on: tx_done clears and is set again by its pulse
    wr_reg(`CONTROL_REG_OFS, 16'h0030);
    rd_reg(`STATUS_REG_OFS, s);
    wr_reg(`STATUS_REG_OFS, 16'hFFBF);
    rd_reg(`STATUS_REG_OFS, s); chk("tx running", s & 16'h0040, 16'h0000);
    @(posedge ref_clk) done_set <= 1'b1;
    @(posedge ref_clk) done_set <= 1'b0;
    rd_reg(`STATUS_REG_OFS, s); chk("tx done", s & 16'h0040, 16'h0040);
    // manual reset in mid-run reloads the status word
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_reg(`STATUS_REG_OFS, s); chk("rst status", s, `STATUS_RESET);
    final_report;
  end
endmodule // testbench
